/* core/smbl_buf.sv */
`timescale 1ns/1ps
// two-entry buffer, head register drives the outputs directly
module smbl_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] tail, next_head, next_tail;
    logic next_v0, next_v1, v1;
    logic push, pop;

    // ****************************************
    // occupancy
    // ****************************************
    always_comb begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        next_head = out_data;
        next_tail = tail;
        next_v0 = out_valid;
        next_v1 = v1;
        if (pop && v1) begin // second entry moves up
            next_head = tail;
            next_v1 = 1'b0;
        end else if (pop) begin
            next_head = in_data;
            next_v0 = push;
        end else if (push && out_valid) begin
            next_tail = in_data;
            next_v1 = 1'b1;
        end else if (push) begin
            next_head = in_data;
            next_v0 = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
            tail <= '0;
            out_valid <= 1'b0;
            v1 <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            out_data <= next_head;
            tail <= next_tail;
            out_valid <= next_v0;
            v1 <= next_v1;
            in_ready <= ~next_v1; // full only when both entries hold
        end
    end
endmodule : smbl_buf

/* core/smbl_defines.svh */
`ifndef SMBL_DEFINES_SVH
`define SMBL_DEFINES_SVH
// ****************************************
// clock and link rates
// ****************************************
`define SMBL_CLK_HZ 40000000
`define SMBL_SPI_HZ 1000000
`define SMBL_TW_HZ 100000
`define SMBL_SPI_HALF (`SMBL_CLK_HZ / (2 * `SMBL_SPI_HZ))
`define SMBL_TW_QTR (`SMBL_CLK_HZ / (4 * `SMBL_TW_HZ))
// ****************************************
// memory protocol values
// ****************************************
`define SMBL_SPI_READ 8'h03
`define SMBL_SPI_HDR {`SMBL_SPI_READ, 16'h0000}
`define SMBL_SPI_HDR_BITS 5'h17
`define SMBL_BLANK_BYTE 8'hff
`define SMBL_TW_WR_ADDR 8'ha0
`define SMBL_TW_RD_ADDR 8'ha1
`define SMBL_LOAD_BYTES 64
`endif

/* core/smbl_loader.sv */
`timescale 1ns/1ps
`include "smbl_defines.svh"
module smbl_loader #(
    parameter int LOAD_BYTES = `SMBL_LOAD_BYTES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic receiver_role,
    input wire logic [7:0] remote_master_command,
    input wire logic mcu_cfg_start,
    input wire logic cfg_bits_ready,
    input wire logic ext_reset_req,
    input wire logic master_data_in,
    input wire logic master_serial_data_line_in,
    input wire logic master_serial_clock_line_in,
    output logic master_spi_clock_out,
    output logic master_spi_clock_oe,
    output logic master_data_out,
    output logic master_data_out_oe,
    output logic master_select_low,
    output logic master_serial_data_line_out,
    output logic master_serial_data_line_oe,
    output logic master_serial_clock_line_out,
    output logic master_serial_clock_line_oe,
    output logic cfg_valid,
    output logic [7:0] cfg_data,
    input wire logic cfg_ready,
    output logic link_init_start
);
    localparam logic [7:0] SPI_HALF = 8'(`SMBL_SPI_HALF);
    localparam logic [7:0] TW_QTR = 8'(`SMBL_TW_QTR);
    localparam logic [15:0] LAST = 16'(LOAD_BYTES - 1);

    smbl_pkg::smbl_state_type state, next_state;
    logic [2:0] s1, s2;
    logic [7:0] div, next_div, rx, next_rx;
    logic [23:0] tx, next_tx;
    logic [4:0] bcnt, next_bcnt;
    logic [15:0] nbyte, next_nbyte;
    logic [2:0] step, next_step;
    logic [1:0] q, next_q;
    logic pend, next_pend, data_ph, next_data_ph, tw_fail, next_tw_fail;
    logic sel_spi, next_sel_spi, next_link, next_sck, next_mosi, next_cs_n;
    logic next_sck_oe, next_mosi_oe, next_scl_oe, next_sda_oe;
    logic buf_ready, tick, tw, miso_s, sda_s, scl_s;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 3'h7;
            s2 <= 3'h7;
        end else begin
            s1 <= {master_data_in, master_serial_data_line_in, master_serial_clock_line_in};
            s2 <= s1;
        end
    end
    assign {miso_s, sda_s, scl_s} = s2;

    // open-drain lines only ever pull low
    assign master_serial_data_line_out = 1'b0;
    assign master_serial_clock_line_out = 1'b0;

    // ****************************************
    // sequencer
    // ****************************************
    // both masters live side by side, the sequencer just picks one
    always_comb begin
        tw = (state inside {smbl_pkg::ST_TW_START, smbl_pkg::ST_TW_WR,
                            smbl_pkg::ST_TW_RD, smbl_pkg::ST_TW_STOP});
        // stall while a byte waits for buffer room or slave stretches scl
        tick = !pend && (div == (tw ? TW_QTR : SPI_HALF) - 8'h01)
               && !(tw && q == 2'h1 && !scl_s);
        // a stretched quarter parks at its last count instead of wrapping round
        next_div = tick ? 8'h00
                   : ((pend || div == (tw ? TW_QTR : SPI_HALF) - 8'h01) ? div : div + 8'h01);
        next_state = state;
        next_rx = rx;
        next_tx = tx;
        next_bcnt = bcnt;
        next_nbyte = nbyte;
        next_step = step;
        next_q = tw && tick ? q + 2'h1 : q;
        next_pend = pend && !buf_ready;
        next_data_ph = data_ph;
        next_tw_fail = tw_fail;
        next_sel_spi = sel_spi;
        next_sck = master_spi_clock_out;
        next_mosi = master_data_out;
        next_cs_n = master_select_low;
        next_link = link_init_start;
        unique case (state)
            smbl_pkg::ST_SPI: if (tick) begin
                if (!master_spi_clock_out) begin
                    next_sck = 1'b1; // sample on the leading edge
                    next_rx = {rx[6:0], miso_s};
                end else begin
                    next_sck = 1'b0;
                    next_tx = {tx[22:0], 1'b0};
                    next_mosi = tx[22];
                    next_bcnt = bcnt + 5'h01;
                    if (!data_ph && bcnt == `SMBL_SPI_HDR_BITS) begin
                        next_data_ph = 1'b1;
                        next_bcnt = 5'h00;
                    end else if (data_ph && bcnt == 5'h07) begin
                        next_bcnt = 5'h00;
                        next_nbyte = nbyte + 16'h0001;
                        // idle-high data in means no memory behind the port
                        if (nbyte == 16'h0000 && rx == `SMBL_BLANK_BYTE) begin
                            next_cs_n = 1'b1;
                            next_sel_spi = 1'b0;
                            next_nbyte = 16'h0000;
                            next_state = smbl_pkg::ST_TW_START;
                        end else begin
                            next_pend = 1'b1;
                            if (nbyte == LAST) begin
                                next_cs_n = 1'b1;
                                next_state = smbl_pkg::ST_DONE;
                            end
                        end
                    end
                end
            end
            smbl_pkg::ST_TW_START: if (tick && q == 2'h3) begin
                next_tx[23:16] = step == 3'h0 ? `SMBL_TW_WR_ADDR : `SMBL_TW_RD_ADDR;
                next_step = step + 3'h1;
                next_bcnt = 5'h00;
                next_state = smbl_pkg::ST_TW_WR;
            end
            smbl_pkg::ST_TW_WR: if (tick) begin
                if (q == 2'h2) begin
                    next_rx = {rx[6:0], sda_s};
                end else if (q == 2'h3 && bcnt != 5'h08) begin
                    next_bcnt = bcnt + 5'h01;
                    next_tx = {tx[22:0], 1'b0};
                end else if (q == 2'h3) begin
                    next_bcnt = 5'h00;
                    if (rx[0]) begin // no acknowledge: nothing there
                        next_tw_fail = 1'b1;
                        next_state = smbl_pkg::ST_TW_STOP;
                    end else if (step == 3'h1) begin
                        next_tx[23:16] = 8'h00; // single sub-address byte
                        next_step = 3'h2;
                    end else if (step == 3'h2) begin
                        next_step = 3'h3;
                        next_state = smbl_pkg::ST_TW_START; // repeated start
                    end else begin
                        next_state = smbl_pkg::ST_TW_RD;
                    end
                end
            end
            smbl_pkg::ST_TW_RD: if (tick) begin
                if (q == 2'h2 && bcnt != 5'h08) begin
                    next_rx = {rx[6:0], sda_s};
                end else if (q == 2'h3 && bcnt != 5'h08) begin
                    next_bcnt = bcnt + 5'h01;
                end else if (q == 2'h3) begin
                    next_bcnt = 5'h00;
                    next_pend = 1'b1;
                    next_nbyte = nbyte + 16'h0001;
                    if (nbyte == LAST) begin
                        next_state = smbl_pkg::ST_TW_STOP;
                    end
                end
            end
            smbl_pkg::ST_TW_STOP: if (tick && q == 2'h3) begin
                next_state = tw_fail ? smbl_pkg::ST_WAIT_MCU : smbl_pkg::ST_DONE;
            end
            smbl_pkg::ST_WAIT_MCU: if (mcu_cfg_start) begin
                next_state = smbl_pkg::ST_DONE;
            end
            smbl_pkg::ST_DONE: begin
                // no further transfers once loaded
                next_link = link_init_start | cfg_bits_ready;
            end
        endcase
        // receiver role follows the remote interface select
        if (receiver_role && state inside {smbl_pkg::ST_DONE, smbl_pkg::ST_WAIT_MCU}) begin
            next_sel_spi = remote_master_command[7];
        end
        // data-out parks low off spi, ready to serve as reset out
        if (!sel_spi) begin
            next_mosi = 1'b0;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    // registered one cycle after the state, every edge moves by the same lag
    always_comb begin
        next_sck_oe = sel_spi;
        next_mosi_oe = sel_spi | ext_reset_req; // spare pin as reset
        next_scl_oe = 1'b0;
        next_sda_oe = sel_spi & ext_reset_req;
        unique case (state)
            smbl_pkg::ST_TW_START: begin
                next_scl_oe = (q == 2'h0) || (q == 2'h3);
                next_sda_oe = q[1];
            end
            smbl_pkg::ST_TW_WR: begin
                next_scl_oe = (q == 2'h0) || (q == 2'h3);
                next_sda_oe = (bcnt != 5'h08) && !tx[23];
            end
            smbl_pkg::ST_TW_RD: begin
                next_scl_oe = (q == 2'h0) || (q == 2'h3);
                next_sda_oe = (bcnt == 5'h08) && (nbyte != LAST); // last byte not acked
            end
            smbl_pkg::ST_TW_STOP: begin
                next_scl_oe = (q == 2'h0);
                next_sda_oe = !q[1];
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= smbl_pkg::ST_SPI;
            div <= 8'h00;
            rx <= 8'h00;
            tx <= `SMBL_SPI_HDR;
            bcnt <= 5'h00;
            nbyte <= 16'h0000;
            step <= 3'h0;
            q <= 2'h0;
            pend <= 1'b0;
            data_ph <= 1'b0;
            tw_fail <= 1'b0;
            sel_spi <= 1'b1;
            master_spi_clock_out <= 1'b0;
            master_data_out <= 1'b0;
            master_select_low <= 1'b0; // selected from reset, always active low
            master_spi_clock_oe <= 1'b1;
            master_data_out_oe <= 1'b1;
            master_serial_clock_line_oe <= 1'b0;
            master_serial_data_line_oe <= 1'b0;
            link_init_start <= 1'b0;
        end else begin
            state <= next_state;
            div <= next_div;
            rx <= next_rx;
            tx <= next_tx;
            bcnt <= next_bcnt;
            nbyte <= next_nbyte;
            step <= next_step;
            q <= next_q;
            pend <= next_pend;
            data_ph <= next_data_ph;
            tw_fail <= next_tw_fail;
            sel_spi <= next_sel_spi;
            master_spi_clock_out <= next_sck;
            master_data_out <= next_mosi;
            master_select_low <= next_cs_n;
            master_spi_clock_oe <= next_sck_oe;
            master_data_out_oe <= next_mosi_oe;
            master_serial_clock_line_oe <= next_scl_oe;
            master_serial_data_line_oe <= next_sda_oe;
            link_init_start <= next_link;
        end
    end

    // loaded bytes queue here so a stalled consumer loses nothing
    smbl_buf #(.W(8)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(pend),
        .in_data(rx),
        .in_ready(buf_ready),
        .out_valid(cfg_valid),
        .out_ready(cfg_ready),
        .out_data(cfg_data)
    );

    // ****************************************
    // checks
    // ****************************************
    logic [7:0] sck_run, scl_run;
    logic spi_tried;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_run <= 8'h00;
            scl_run <= 8'h00;
            spi_tried <= 1'b0;
        end else begin
            sck_run <= (next_sck != master_spi_clock_out) ? 8'h01 : sck_run + 8'h01;
            scl_run <= (next_scl_oe != master_serial_clock_line_oe) ? 8'h01 : scl_run + 8'h01;
            spi_tried <= spi_tried | (state == smbl_pkg::ST_SPI);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_spi_high;
        $fell(master_spi_clock_out) |-> $past(sck_run) == SPI_HALF;
    endproperty
    a_spi_high: assert property (p_spi_high) else $error("sck high time wrong");
    property p_sck_idle;
        master_select_low |-> !master_spi_clock_out;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck not idle low");
    property p_spi_first;
        tw |-> spi_tried && !sel_spi && master_select_low;
    endproperty
    a_spi_first: assert property (p_spi_first) else $error("2-wire before spi");
    property p_tw_high;
        // only rises closing a bit or a start; the first pull-down follows a long idle
        ($rose(master_serial_clock_line_oe) && q == 2'h3) |-> $past(scl_run) == TW_QTR + TW_QTR;
    endproperty
    a_tw_high: assert property (p_tw_high) else $error("scl high time wrong");
    property p_dev_addr;
        (state == smbl_pkg::ST_TW_WR && bcnt == 5'h00 && q == 2'h0
            && (step == 3'h1 || step == 3'h4))
            |-> tx[23:16] == (step == 3'h1 ? `SMBL_TW_WR_ADDR : `SMBL_TW_RD_ADDR);
    endproperty
    a_dev_addr: assert property (p_dev_addr) else $error("bad device address");
    property p_dir;
        !(master_spi_clock_oe && master_serial_clock_line_oe);
    endproperty
    a_dir: assert property (p_dir) else $error("both clocks driven");
    property p_idle;
        (state == smbl_pkg::ST_WAIT_MCU && !mcu_cfg_start) |=> state == smbl_pkg::ST_WAIT_MCU;
    endproperty
    a_idle: assert property (p_idle) else $error("left idle without mcu");
    property p_link;
        (state == smbl_pkg::ST_DONE && cfg_bits_ready) |=> link_init_start;
    endproperty
    a_link: assert property (p_link) else $error("link not started");
    property p_hdr;
        (state == smbl_pkg::ST_SPI && !data_ph && bcnt == 5'h00 && !master_spi_clock_out)
            |-> tx == `SMBL_SPI_HDR;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad spi header");
    property p_rst_pin;
        (ext_reset_req && !sel_spi) |=> master_data_out_oe && !master_data_out;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not driven");
endmodule : smbl_loader

/* core/smbl_pkg.sv */
package smbl_pkg;
    // boot sequencer states
    typedef enum logic [2:0] {
        ST_SPI,
        ST_TW_START,
        ST_TW_WR,
        ST_TW_RD,
        ST_TW_STOP,
        ST_WAIT_MCU,
        ST_DONE
    } smbl_state_type;
endpackage : smbl_pkg

/* verif/smbl_mem_model.sv */
`timescale 1ns/1ps
// ****************************************
// behavioural spi and 2-wire config memories
// ****************************************
module smbl_mem_model (
    input wire logic spi_present,
    input wire logic tw_present,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    int sbit;
    int cnt;
    int starts;
    int p;
    int nb;
    logic rd;
    logic [23:0] hdr;
    logic [7:0] shift;
    logic [7:0] cur;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic [7:0] sub;
    // content pattern, first byte 8'h30 and not 8'hff so the spi probe sees a memory
    function automatic logic [7:0] mbyte(input int i);
        return 8'h30 + 8'(i) * 8'h11;
    endfunction : mbyte
    initial begin
        sbit = 0;
        cnt = 0;
        starts = 0;
        rd = 1'b0;
        hdr = '0;
        shift = '0;
        miso = 1'b1;
        sda_pull = 1'b0;
        wr_addr = '0;
        rd_addr = '0;
        sub = '0;
    end
    // spi: header captured on rise, data shifted out on fall (mode 0)
    always @(negedge cs_n) sbit = 0;
    always @(posedge cs_n) miso = 1'b1; // pull-up once deselected
    always @(posedge sck) begin
        if (!cs_n) begin
            if (sbit < 24) hdr = {hdr[22:0], mosi};
            sbit++;
        end
    end
    always @(negedge sck) begin
        if (!cs_n && spi_present && sbit >= 24) begin
            cur = mbyte((sbit - 24) / 8);
            miso = cur[7 - ((sbit - 24) % 8)];
        end
    end
    // 2-wire: start, stop and bit counting from wire levels
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            cnt = 0;
            starts++;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            cnt = 0;
            rd = 1'b0;
        end
    end
    always @(posedge scl) begin
        shift = {shift[6:0], sda};
        cnt++;
    end
    // slot after each byte is the ack; read data driven while scl low
    always @(negedge scl) begin
        if (cnt > 0) begin
            p = cnt % 9;
            nb = cnt / 9;
            if (p == 8 && nb == 0) begin
                rd = shift[0];
                if (shift[0]) rd_addr = shift;
                else wr_addr = shift;
            end else if (p == 8 && nb == 1 && !rd) begin
                sub = shift;
            end
            // master nack on a read byte: stop driving, let the stop through
            if (rd && nb > 1 && p == 0 && shift[0]) rd = 1'b0;
            if (rd && nb > 0) begin
                cur = mbyte(nb - 1);
                sda_pull = (p == 8) ? 1'b0 : ~cur[7 - p];
            end else begin
                sda_pull = tw_present && (p == 8);
            end
        end
    end
endmodule : smbl_mem_model

/* verif/tb_serial_master_boot_loader.sv */
`timescale 1ns/1ps
module tb_serial_master_boot_loader;
    localparam int NB = 4;
    logic clk, rst_n, rx_role, mcu_start, bits_rdy, ext_rst, cfg_ready;
    logic [7:0] cmd;
    logic miso, sck, sck_oe, mosi, mosi_oe, cs_n, pull;
    logic sda_o, sda_oe, scl_o, scl_oe, cfg_valid, link, sda_w, scl_w;
    logic [7:0] cfg_data;
    logic spi_on, tw_on;
    logic [7:0] got[$];
    int n_fail = 0;
    int n_tests = 0;
    // open-drain wires with pull-ups
    assign scl_w = !(scl_oe && !scl_o);
    assign sda_w = !((sda_oe && !sda_o) || pull);
    smbl_loader #(.LOAD_BYTES(NB)) uut (
        .clk(clk), .rst_n(rst_n), .receiver_role(rx_role), .remote_master_command(cmd),
        .mcu_cfg_start(mcu_start), .cfg_bits_ready(bits_rdy), .ext_reset_req(ext_rst),
        .master_data_in(miso), .master_serial_data_line_in(sda_w),
        .master_serial_clock_line_in(scl_w), .master_spi_clock_out(sck),
        .master_spi_clock_oe(sck_oe), .master_data_out(mosi), .master_data_out_oe(mosi_oe),
        .master_select_low(cs_n), .master_serial_data_line_out(sda_o),
        .master_serial_data_line_oe(sda_oe), .master_serial_clock_line_out(scl_o),
        .master_serial_clock_line_oe(scl_oe), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
        .cfg_ready(cfg_ready), .link_init_start(link));
    smbl_mem_model mem (
        .spi_present(spi_on), .tw_present(tw_on), .sck(sck), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .scl(scl_w), .sda(sda_w), .sda_pull(pull));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // stream monitor: a byte moves when valid and ready meet at an edge
    always @(posedge clk) if (rst_n && cfg_valid === 1'b1 && cfg_ready) got.push_back(cfg_data);
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic test_done;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic start_run(input logic s, input logic t);
        @(negedge clk);
        spi_on = s;
        tw_on = t;
        rst_n = 1'b0;
        got.delete();
        mem.starts = 0;
        mem.sda_pull = 1'b0;
        repeat (6) @(negedge clk);
        chk("cs_in_reset", 0, cs_n);
        chk("sck_in_reset", 0, sck);
        rst_n = 1'b1;
    endtask : start_run
    task automatic wait_bytes(input int n);
        int i;
        for (i = 0; i < 60000 && got.size() < n; i++) @(posedge clk);
        chk("byte_count", n, got.size());
        for (i = 0; i < n; i++) chk("cfg_data", 8'h30 + 8'(i) * 8'h11, got[i]);
    endtask : wait_bytes
    // one full period of sck or scl, in system clocks
    task automatic period(input bit tw, output int n);
        int i;
        n = 0;
        for (i = 0; i < 3000 && (tw ? scl_w : sck); i++) @(posedge clk);
        for (i = 0; i < 3000 && !(tw ? scl_w : sck); i++) @(posedge clk);
        for (i = 0; i < 3000 && (tw ? scl_w : sck); i++) begin
            @(posedge clk);
            n++;
        end
        for (i = 0; i < 3000 && !(tw ? scl_w : sck); i++) begin
            @(posedge clk);
            n++;
        end
    endtask : period
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_spi_boot;
        int n;
        int i;
        bits_rdy = 1'b0;
        cfg_ready = 1'b0;
        start_run(1'b1, 1'b0);
        chk("sck_oe", 1, sck_oe);
        chk("tw_oe", 0, scl_oe | sda_oe);
        period(1'b0, n);
        chk("sck_period", 40, n);
        // receiver stalls: buffer fills and the memory clock must park low
        repeat (4000) @(posedge clk);
        n = 0;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (sck !== 1'b0) n++;
        end
        chk("sck_parked", 0, n);
        chk("head_valid", 1, cfg_valid);
        chk("head_data", 8'h30, cfg_data);
        chk("cs_held", 0, cs_n);
        @(negedge clk);
        cfg_ready = 1'b1;
        wait_bytes(NB);
        chk("spi_header", 24'h030000, mem.hdr);
        for (i = 0; i < 2000 && cs_n !== 1'b1; i++) @(posedge clk);
        chk("cs_idle", 1, cs_n);
        chk("sck_idle", 0, sck);
        chk("no_tw_start", 0, mem.starts);
        chk("link_early", 0, link);
        @(negedge clk);
        bits_rdy = 1'b1;
        repeat (3) @(posedge clk);
        chk("link_start", 1, link);
    endtask : t_spi_boot
    task automatic t_tw_boot;
        int n;
        int i;
        start_run(1'b0, 1'b1);
        for (i = 0; i < 5000 && cs_n !== 1'b1; i++) @(posedge clk);
        chk("spi_probe_end", 1, cs_n);
        chk("tw_after_spi", 0, mem.starts);
        for (i = 0; i < 3000 && mem.cnt < 2; i++) @(posedge clk);
        period(1'b1, n);
        chk("scl_period", 400, n);
        chk("sck_oe_tw", 0, sck_oe);
        chk("link_loading", 0, link);
        wait_bytes(NB);
        chk("wr_addr", 8'ha0, mem.wr_addr);
        chk("rd_addr", 8'ha1, mem.rd_addr);
        chk("sub_addr", 8'h00, mem.sub);
        chk("starts", 2, mem.starts);
        repeat (1000) @(posedge clk);
        chk("link_after", 1, link);
        // transmitter role keeps the boot selection
        @(negedge clk);
        cmd = 8'h80;
        repeat (5) @(posedge clk);
        chk("tx_keeps_sel", 0, sck_oe);
        @(negedge clk);
        cmd = 8'h00;
    endtask : t_tw_boot
    task automatic t_no_mem;
        bits_rdy = 1'b1;
        start_run(1'b0, 1'b0);
        repeat (9000) @(posedge clk);
        chk("idle_link", 0, link);
        chk("idle_valid", 0, cfg_valid);
        chk("idle_tw_oe", 0, scl_oe | sda_oe);
        chk("one_tw_try", 1, mem.starts);
        @(negedge clk);
        mcu_start = 1'b1;
        @(negedge clk);
        mcu_start = 1'b0;
        repeat (4) @(posedge clk);
        chk("mcu_link", 1, link);
        // receiver role: select follows command bit 7, spare pin as reset
        @(negedge clk);
        rx_role = 1'b1;
        cmd = 8'h80;
        repeat (5) @(posedge clk);
        chk("spi_sel_sck", 1, sck_oe);
        chk("spi_sel_mosi", 1, mosi_oe);
        chk("spi_sel_scl", 0, scl_oe);
        @(negedge clk);
        ext_rst = 1'b1;
        repeat (5) @(posedge clk);
        chk("spare_sda", 1, sda_oe);
        @(negedge clk);
        cmd = 8'h00;
        repeat (5) @(posedge clk);
        chk("tw_sel_sck", 0, sck_oe);
        chk("spare_mosi_oe", 1, mosi_oe);
        chk("spare_mosi", 0, mosi);
        @(negedge clk);
        ext_rst = 1'b0;
        repeat (5) @(posedge clk);
        chk("tw_sel_mosi", 0, mosi_oe);
        rx_role = 1'b0;
    endtask : t_no_mem
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst_n = 1'b0;
        rx_role = 1'b0;
        cmd = 8'h00;
        mcu_start = 1'b0;
        bits_rdy = 1'b0;
        ext_rst = 1'b0;
        cfg_ready = 1'b0;
        spi_on = 1'b0;
        tw_on = 1'b0;
        t_spi_boot();
        t_tw_boot();
        t_no_mem();
        test_done();
    end
    // about twice the expected run, well under the cycle budget
    initial begin
        #2000000;
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
endmodule : tb_serial_master_boot_loader
